// ---- inc/cca_map.svh ----
// named offsets, field positions, reset values and timing counts of the transceiver core
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

// ==========================================
// clock and time figures
`define CCA_CLK_NS 8
`define CCA_DOM_TO_NS 800000
`define CCA_RECOV_NS 4000
`define CCA_CLAMP_NS 90
`define CCA_MODE_MAX_NS 10000
`define CCA_TMR_W 20
`define CCA_DOM_TO_CYC 20'((`CCA_DOM_TO_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)
`define CCA_RECOV_CYC 20'((`CCA_RECOV_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)
`define CCA_CLAMP_CYC 20'((`CCA_CLAMP_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)
`define CCA_MODE_MAX_CYC (`CCA_MODE_MAX_NS / `CCA_CLK_NS)

// ==========================================
// register map
`define CCA_AW 12
`define CCA_REG_CTRL 12'h000
`define CCA_REG_STAT 12'h004
`define CCA_CTRL_SIL_BIT 0
`define CCA_CTRL_RST 1'h0
`define CCA_RESP_OKAY 2'h0
`define CCA_RESP_SLVERR 2'h2
`define CCA_STAT_W 8

`endif

// ---- inc/cca_pkg.sv ----
// types shared by the transceiver core files
package cca_pkg;

  // ==========================================
  // operating modes
  typedef enum logic [1:0] {
    CCA_UNPOWERED = 2'b00,
    CCA_SILENT = 2'b01,
    CCA_NORMAL = 2'b10
  } cca_mode_e;

endpackage

// ---- core/cca_timer.sv ----
// saturating run-length timer on the system clock
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_timer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // control
  input wire logic run_i,
  input wire logic [`CCA_TMR_W-1:0] limit_i,
  // result
  output logic done_o
);

  logic [`CCA_TMR_W-1:0] count;

  // ==========================================
  // counter: clears whenever run drops
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (!run_i) begin
      count <= '0;
    end else if (count != limit_i) begin
      count <= count + 1'b1;
    end
  end

  assign done_o = run_i && (count == limit_i);

endmodule // cca_timer

// ---- core/cca_axil.sv ----
// axi4-lite register slave: control and status words
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_axil (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`CCA_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`CCA_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // core side
  output logic force_silent_o,
  input wire logic [`CCA_STAT_W-1:0] status_i
);

  logic aw_held;
  logic w_held;
  logic [`CCA_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = (aw_addr == `CCA_REG_CTRL);
  wire wr_ok = wr_ctrl || (aw_addr == `CCA_REG_STAT);
  wire rd_ctrl = (s_axi_araddr == `CCA_REG_CTRL);
  wire rd_stat = (s_axi_araddr == `CCA_REG_STAT);
  wire [31:0] rd_word = rd_ctrl ? {31'h0000_0000, force_silent_o} :
                        rd_stat ? {24'h00_0000, status_i} : 32'h0000_0000;

  // ==========================================
  // write path: address and data in either order
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCA_RESP_OKAY;
      force_silent_o <= `CCA_CTRL_RST;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
        if (wr_ctrl && w_strb[0]) begin
          force_silent_o <= w_data[`CCA_CTRL_SIL_BIT];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================
  // read path: answer one cycle after the address is taken
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rd_ctrl || rd_stat) ? `CCA_RESP_OKAY : `CCA_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // cca_axil

// ---- core/cca_core.sv ----
// mode control and fail-safe logic of the can transceiver
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "cca_map.svh"

module cca_core #(
  parameter logic [`CCA_TMR_W-1:0] DOM_TO_CYCLES = `CCA_DOM_TO_CYC
) (
  // clock and power-up reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // controller pins
  input wire logic txd_i,
  input wire logic txd_driven_i,
  input wire logic quiet_i,
  input wire logic quiet_driven_i,
  output logic rxd_o,
  // analog front end
  input wire logic bus_comparator_dom_i,
  input wire logic rxd_pin_level_i,
  input wire logic vcc_uv_i,
  input wire logic io_supply_uv_i,
  input wire logic overtemp_i,
  output logic bus_drive_dom_o,
  output logic [1:0] mode_o,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`CCA_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`CCA_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  cca_pkg::cca_mode_e state;
  cca_pkg::cca_mode_e next_state;
  logic dom_to_fault;
  logic ot_fault;
  logic clamp_fault;
  logic force_silent;
  logic dom_done;
  logic recov_done;
  logic clamp_done;

  // ==========================================
  // pin defaults and decoding
  // undriven pins resolve as the internal pulls would
  wire txd_eff = txd_driven_i ? txd_i : 1'b1;
  wire quiet_eff = quiet_driven_i ? quiet_i : 1'b0;
  wire uv = vcc_uv_i || io_supply_uv_i;
  wire powered = (state != cca_pkg::CCA_UNPOWERED);
  wire mismatch = bus_comparator_dom_i && rxd_pin_level_i;
  wire go_normal = !quiet_eff && txd_eff && !clamp_fault && !force_silent;
  wire go_silent = quiet_eff || clamp_fault || force_silent;
  wire drv_ok = (state == cca_pkg::CCA_NORMAL) && !dom_to_fault && !ot_fault &&
                !clamp_fault && !uv;
  wire next_drv = drv_ok && !txd_eff;
  wire next_rxd = powered ? !bus_comparator_dom_i : 1'b1;
  wire [`CCA_STAT_W-1:0] status = {1'b0, uv, clamp_fault, ot_fault, dom_to_fault, state, state[0]};

  // ==========================================
  // timers on the internal clock
  // a free clock stands in for the on-chip oscillator
  cca_timer u_dom_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .run_i(!txd_eff),
    .limit_i(DOM_TO_CYCLES),
    .done_o(dom_done)
  );

  cca_timer u_recov_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .run_i(txd_eff && dom_to_fault),
    .limit_i(`CCA_RECOV_CYC),
    .done_o(recov_done)
  );

  cca_timer u_clamp_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .run_i(mismatch && powered),
    .limit_i(`CCA_CLAMP_CYC),
    .done_o(clamp_done)
  );

  // ==========================================
  // register slave
  cca_axil u_regs (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .force_silent_o(force_silent),
    .status_i(status)
  );

  // ==========================================
  // mode state machine
  // quiet pin is not looked at while a supply is low
  always_comb begin
    next_state = state;
    unique case (state)
      cca_pkg::CCA_UNPOWERED: begin
        if (!uv) begin
          next_state = cca_pkg::CCA_SILENT;
        end
      end
      cca_pkg::CCA_SILENT: begin
        if (uv) begin
          next_state = cca_pkg::CCA_UNPOWERED;
        end else if (go_normal) begin
          next_state = cca_pkg::CCA_NORMAL;
        end
      end
      cca_pkg::CCA_NORMAL: begin
        if (uv) begin
          next_state = cca_pkg::CCA_UNPOWERED;
        end else if (go_silent) begin
          next_state = cca_pkg::CCA_SILENT;
        end
      end
      default: begin
        next_state = cca_pkg::CCA_UNPOWERED;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= cca_pkg::CCA_UNPOWERED;
      mode_o <= 2'h0;
      bus_drive_dom_o <= 1'b0;
      rxd_o <= 1'b1;
    end else begin
      state <= next_state;
      mode_o <= next_state;
      bus_drive_dom_o <= next_drv;
      rxd_o <= next_rxd;
    end
  end

  // ==========================================
  // fault latches
  // each set term wins over its clear term
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dom_to_fault <= 1'b0;
      ot_fault <= 1'b0;
      clamp_fault <= 1'b0;
    end else begin
      if (dom_done) begin
        dom_to_fault <= 1'b1;
      end else if (recov_done) begin
        dom_to_fault <= 1'b0;
      end
      if (overtemp_i) begin
        ot_fault <= 1'b1;
      end else if (txd_eff) begin
        ot_fault <= 1'b0;
      end
      if (clamp_done) begin
        clamp_fault <= 1'b1;
      end else if (!powered || !rxd_pin_level_i) begin
        clamp_fault <= 1'b0;
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  localparam int RecovCyc = `CCA_RECOV_CYC;
  localparam int ClampCyc = `CCA_CLAMP_CYC;

  logic [`CCA_TMR_W-1:0] low_run;
  logic [`CCA_TMR_W-1:0] high_run;
  logic [`CCA_TMR_W-1:0] mis_run;

  function automatic logic [`CCA_TMR_W-1:0] sat_inc(input logic [`CCA_TMR_W-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction

  // run lengths seen only by the checks
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_run <= '0;
      high_run <= '0;
      mis_run <= '0;
    end else begin
      low_run <= txd_eff ? '0 : sat_inc(low_run);
      high_run <= !txd_eff ? '0 : sat_inc(high_run);
      mis_run <= !mismatch ? '0 : sat_inc(mis_run);
    end
  end

  a_normal_entry: assert property (
    $rose(state == cca_pkg::CCA_NORMAL) |-> $past(!quiet_eff && txd_eff))
    else $error("normal entered without quiet low and txd high");

  a_drive_cause: assert property (
    bus_drive_dom_o |-> $past(state == cca_pkg::CCA_NORMAL && !txd_eff &&
                              !dom_to_fault && !ot_fault && !clamp_fault))
    else $error("bus driven dominant without cause");

  a_rxd_follow: assert property (
    powered |=> rxd_o == !$past(bus_comparator_dom_i))
    else $error("receive output does not follow the bus");

  a_quiet_silent: assert property (
    (state == cca_pkg::CCA_NORMAL && quiet_eff && !uv) |=>
      (state == cca_pkg::CCA_SILENT) ##1 !bus_drive_dom_o)
    else $error("quiet high did not give silent mode");

  a_unpowered_out: assert property (
    uv |=> !powered ##1 (!bus_drive_dom_o && rxd_o))
    else $error("undervoltage did not release the bus");

  a_dom_timeout: assert property (
    $rose(dom_to_fault) |-> low_run > DOM_TO_CYCLES)
    else $error("dominant timeout fired too early");

  a_dom_recover: assert property (
    $fell(dom_to_fault) |-> high_run > RecovCyc)
    else $error("dominant timeout cleared too early");

  a_ot_hold: assert property (
    ot_fault && (overtemp_i || !txd_eff) |=> ot_fault ##0 !bus_drive_dom_o)
    else $error("overtemperature released too early");

  a_clamp_set: assert property (
    $rose(clamp_fault) |-> $past(mis_run) >= ClampCyc)
    else $error("clamp fault without debounced mismatch");

  a_clamp_release: assert property (
    clamp_fault && !rxd_pin_level_i && !mismatch |=> !clamp_fault)
    else $error("clamp fault not released on low receive pin");

  a_pull_default: assert property (
    (!txd_driven_i && !quiet_driven_i && state == cca_pkg::CCA_SILENT &&
     !uv && !clamp_fault && !force_silent) |=> state == cca_pkg::CCA_NORMAL)
    else $error("floating pins did not select normal mode");

  a_dom_bound: assert property (
    low_run > DOM_TO_CYCLES |-> dom_to_fault)
    else $error("dominant timeout did not fire in time");

  a_dom_clear: assert property (
    txd_eff |=> !dom_done)
    else $error("dominant timer kept running on txd high");

  a_txd_follow: assert property (
    (state == cca_pkg::CCA_NORMAL && !dom_to_fault && !ot_fault && !clamp_fault && !uv) |=>
      bus_drive_dom_o == !$past(txd_eff))
    else $error("driver does not follow transmit data");

  a_silent_drive: assert property (
    state != cca_pkg::CCA_NORMAL |=> !bus_drive_dom_o)
    else $error("driver active outside normal mode");

  a_silent_normal: assert property (
    (state == cca_pkg::CCA_SILENT && go_normal && !uv) |=> state == cca_pkg::CCA_NORMAL)
    else $error("normal mode not entered on request");

  a_uv_quiet: assert property (
    uv |=> state == cca_pkg::CCA_UNPOWERED)
    else $error("mode left unpowered during undervoltage");

  a_rxd_unpowered: assert property (
    !powered |=> rxd_o)
    else $error("receive output not recessive while unpowered");

  a_ot_set: assert property (
    overtemp_i |=> ot_fault ##1 !bus_drive_dom_o)
    else $error("overtemperature did not stop the driver");

  a_clamp_silent: assert property (
    (clamp_fault && !uv) |=> state != cca_pkg::CCA_NORMAL)
    else $error("clamp fault did not force silent mode");

  // ==========================================
  // cover points
  c_normal: cover property (
    state == cca_pkg::CCA_SILENT ##1 state == cca_pkg::CCA_NORMAL);
  c_dom_timeout: cover property ($rose(dom_to_fault));
  c_clamp: cover property ($rose(clamp_fault));
  c_overtemp: cover property ($fell(ot_fault));
  c_uv: cover property ($rose(state == cca_pkg::CCA_UNPOWERED));

endmodule // cca_core

// ---- bench/cca_ctrl_model.sv ----
// controller-side pin model driving transmit data and the quiet select pin
`timescale 1ns/1ps

module cca_ctrl_model (
  // clock
  input wire logic clk_sys_i,
  // commands from the bench
  input wire logic want_quiet_i,
  input wire logic tx_level_i,
  input wire logic release_i,
  // pins toward the transceiver
  output logic txd_o,
  output logic txd_driven_o,
  output logic quiet_o,
  output logic quiet_driven_o
);
  logic junk = 1'h0;

  // ==========================================
  // pin drivers
  // released pins toggle, so the core has to rely on its own pulls
  always @(posedge clk_sys_i) begin
    junk <= ~junk;
    txd_driven_o <= ~release_i;
    quiet_driven_o <= ~release_i;
    txd_o <= release_i ? junk : tx_level_i;
    quiet_o <= release_i ? ~junk : want_quiet_i;
  end
endmodule // cca_ctrl_model

// ---- bench/cca_core_tb.sv ----
// self-checking bench for the transceiver mode and fail-safe core
`timescale 1ns/1ps
`include "cca_map.svh"

`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module cca_core_tb;
  logic clk_sys_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic q = 1'h1;
  logic t = 1'h1;
  logic rel = 1'h0;
  logic comp = 1'h0;
  logic clamp = 1'h0;
  logic vuv = 1'h0;
  logic iuv = 1'h0;
  logic ot = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic awr, wr, bv, arr, rv, txd, txd_dv, qp, q_dv, rxd, drv;
  logic [1:0] br, rr, mode, resp;
  logic [31:0] rd, rdat;
  int error_cnt = 0;
  int samples_checked = 0;
  // bits: quiet, txd, comparator, mode[1:0], drive, receive
  logic [6:0] rows [8] = '{7'h65, 7'h74, 7'h05, 7'h29, 7'h1a, 7'h29, 7'h0b, 7'h65};

  always #4 clk_sys_i = ~clk_sys_i;

  cca_ctrl_model u_cca_ctrl_model (.clk_sys_i(clk_sys_i), .want_quiet_i(q), .tx_level_i(t),
    .release_i(rel), .txd_o(txd), .txd_driven_o(txd_dv), .quiet_o(qp), .quiet_driven_o(q_dv));

  cca_core #(.DOM_TO_CYCLES(20'h0_0014)) u_cca_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .txd_i(txd), .txd_driven_i(txd_dv), .quiet_i(qp), .quiet_driven_i(q_dv), .rxd_o(rxd),
    .bus_comparator_dom_i(comp), .rxd_pin_level_i(clamp | rxd), .vcc_uv_i(vuv),
    .io_supply_uv_i(iuv), .overtemp_i(ot), .bus_drive_dom_o(drv), .mode_o(mode),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr));

  // ==========================================
  // helpers
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task pins(input logic qv, input logic tv, input logic cv);
    @(posedge clk_sys_i);
    q <= qv;
    t <= tv;
    comp <= cv;
  endtask

  task axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    awv <= 1'h1;
    wv <= 1'h1;
    awa <= a;
    wd <= d;
    bre <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (awv && awr) awv <= 1'h0;
      if (wv && wr) wv <= 1'h0;
      if (bre && bv) begin
        resp = br;
        bre <= 1'h0;
      end
    end while (awv || wv || bre);
  endtask

  task axr(input logic [11:0] a);
    @(posedge clk_sys_i);
    arv <= 1'h1;
    ara <= a;
    rre <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      if (arv && arr) arv <= 1'h0;
      if (rre && rv) begin
        rdat = rd;
        resp = rr;
        rre <= 1'h0;
      end
    end while (arv || rre);
  endtask

  task end_of_test;
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // watchdog, about six times the expected run
  initial begin
    wt(5000);
    error_cnt++;
    end_of_test;
  end

  // ==========================================
  // main sequence
  initial begin
    wt(6);
    reset_n_i <= 1'h1;
    foreach (rows[i]) begin
      pins(rows[i][6], rows[i][5], rows[i][4]);
      wt(5);
      `CHK(mode, rows[i][3:2], "mode")
      `CHK(drv, rows[i][1], "driver")
      `CHK(rxd, rows[i][0], "receive")
    end
    @(posedge clk_sys_i);
    rel <= 1'h1;
    wt(6);
    `CHK(mode, 2'h2, "floating pins mode")
    repeat (6) begin
      @(posedge clk_sys_i);
      `CHK(drv, 1'h0, "floating txd drive")
    end
    pins(1'h0, 1'h1, 1'h0);
    rel <= 1'h0;
    // dominant timeout, restarted once before expiry
    pins(1'h0, 1'h0, 1'h0);
    wt(15);
    pins(1'h0, 1'h1, 1'h0);
    wt(2);
    pins(1'h0, 1'h0, 1'h0);
    wt(15);
    `CHK(drv, 1'h1, "timer restart")
    wt(15);
    `CHK(drv, 1'h0, "timeout")
    axr(`CCA_REG_STAT);
    `CHK(rdat[3], 1'h1, "timeout flag")
    pins(1'h0, 1'h1, 1'h0);
    wt(100);
    pins(1'h0, 1'h0, 1'h0);
    wt(5);
    `CHK(drv, 1'h0, "short recovery")
    pins(1'h0, 1'h1, 1'h0);
    wt(520);
    pins(1'h0, 1'h0, 1'h0);
    wt(5);
    `CHK(drv, 1'h1, "recovered")
    // overtemperature with txd still low
    @(posedge clk_sys_i);
    ot <= 1'h1;
    wt(3);
    `CHK(drv, 1'h0, "hot")
    @(posedge clk_sys_i);
    ot <= 1'h0;
    wt(3);
    `CHK(drv, 1'h0, "cool but txd low")
    pins(1'h0, 1'h1, 1'h0);
    wt(3);
    pins(1'h0, 1'h0, 1'h0);
    wt(4);
    `CHK(drv, 1'h1, "driver back")
    // receive pin clamped high
    pins(1'h0, 1'h1, 1'h1);
    clamp <= 1'h1;
    wt(8);
    `CHK(mode, 2'h2, "debounce")
    wt(10);
    `CHK(mode, 2'h1, "clamp silent")
    @(posedge clk_sys_i);
    clamp <= 1'h0;
    wt(6);
    `CHK(mode, 2'h2, "clamp release")
    // undervoltage on the main supply, then on the io supply
    pins(1'h0, 1'h0, 1'h1);
    vuv <= 1'h1;
    wt(4);
    `CHK(mode, 2'h0, "main uv")
    `CHK(drv, 1'h0, "uv drive")
    `CHK(rxd, 1'h1, "uv receive")
    pins(1'h1, 1'h0, 1'h1);
    wt(3);
    `CHK(mode, 2'h0, "quiet ignored")
    @(posedge clk_sys_i);
    vuv <= 1'h0;
    iuv <= 1'h1;
    wt(3);
    `CHK(mode, 2'h0, "io uv")
    pins(1'h0, 1'h1, 1'h0);
    iuv <= 1'h0;
    wt(6);
    `CHK(mode, 2'h2, "supplies back")
    // register bus
    axr(`CCA_REG_STAT);
    `CHK(rdat, 32'h0000_0004, "status normal")
    axw(`CCA_REG_CTRL, 32'h0000_0001);
    `CHK(resp, `CCA_RESP_OKAY, "write resp")
    wt(3);
    `CHK(mode, 2'h1, "forced silent")
    axr(`CCA_REG_CTRL);
    `CHK(rdat, 32'h0000_0001, "ctrl readback")
    axr(12'h008);
    `CHK(resp, `CCA_RESP_SLVERR, "unmapped")
    `CHK(rdat, 32'h0000_0000, "unmapped data")
    axw(`CCA_REG_CTRL, 32'h0000_0000);
    wt(4);
    `CHK(mode, 2'h2, "force lifted")
    // power-up reset in mid-run
    @(posedge clk_sys_i);
    reset_n_i <= 1'h0;
    wt(2);
    `CHK(mode, 2'h0, "reset mode")
    `CHK(rxd, 1'h1, "reset receive")
    reset_n_i <= 1'h1;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    `CHK(mode, 2'h1, "first edge after reset")
    @(posedge clk_sys_i);
    `CHK(mode, 2'h2, "normal after reset")
    `CHK(drv, 1'h0, "idle driver after reset")
    end_of_test;
  end
endmodule // cca_core_tb
